//--- mpa_fifo.v
// octet fifo with registered read data
`timescale 1ns/100ps
module mpa_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clk,
  input wire rst,
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  output reg outValid,
  input wire outReady,
  output reg [WIDTH-1:0] outData
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wrPtr;
  reg [AW-1:0] rdPtr;
  reg [AW:0] count;
  wire push;
  wire pop;

  assign inReady = (count != DEPTH[AW:0]);
  assign push = inValid && inReady;
  // output stage refills whenever it is empty or being drained
  assign pop = (count != {(AW+1){1'b0}}) && (!outValid || outReady);

  always @(posedge clk) begin
    if (push) begin
      mem[wrPtr] <= inData;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wrPtr <= {AW{1'b0}};
      rdPtr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
      outValid <= 1'b0;
      outData <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        wrPtr <= wrPtr + 1'b1;
      end
      if (pop) begin
        rdPtr <= rdPtr + 1'b1;
        outData <= mem[rdPtr];
        outValid <= 1'b1;
      end else if (outReady) begin
        outValid <= 1'b0;
      end
      count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule // mpa_fifo

//--- mpa_framer.v
// aggregated payload builder/parser and information element framer
`timescale 1ns/100ps
`include "mpa_regs.vh"
module mpa_framer (
  input wire clk,
  input wire rst,
  input wire lenValid,
  output wire lenReady,
  input wire [15:0] lenData,
  output reg lenRejected,
  input wire aggStart,
  input wire ieTxStart,
  input wire [7:0] ieTxType,
  input wire [7:0] ieTxLen,
  input wire [15:0] ieTxOrg,
  output reg ieTxRefused,
  input wire unitValid,
  output wire unitReady,
  input wire [7:0] unitData,
  output wire txBusy,
  output reg txValid,
  input wire txReady,
  output reg [7:0] txData,
  output reg txLast,
  input wire rxIeMode,
  input wire rxValid,
  input wire [7:0] rxData,
  input wire rxLast,
  output reg rxOutValid,
  output reg [7:0] rxOutData,
  output reg rxOutLast,
  output reg [2:0] rxOutIdx,
  output reg ieStart,
  output reg [7:0] ieType,
  output reg [7:0] ieLength,
  output reg orgSpecValid,
  output reg [15:0] orgSpec,
  output reg rxError
);
  // ***************************************************************
  // helpers
  // ***************************************************************
  function [15:0] align4;
    input [15:0] v;
    begin
      align4 = (v + `MPA_ALIGN_MASK) & ~`MPA_ALIGN_MASK;
    end
  endfunction

  function knownType;
    input [7:0] t;
    begin
      knownType = (t <= 8'h02) || (t >= 8'h08 && t <= 8'h18) ||
        (t == 8'hfa) || (t == 8'hfb) || (t == `MPA_APP_SPECIFIC);
    end
  endfunction

  localparam TX_IDLE = 3'h0;
  localparam TX_HDR = 3'h1;
  localparam TX_PAD = 3'h2;
  localparam TX_UNIT = 3'h3;
  localparam TX_ILEN = 3'h4;
  localparam TX_IORG0 = 3'h5;
  localparam TX_IORG1 = 3'h6;

  // ***************************************************************
  // unit octet buffer
  // ***************************************************************
  wire fifoValid;
  wire fifoReady;
  wire [7:0] fifoData;
  mpa_fifo #(.WIDTH(8), .DEPTH(`MPA_FIFO_DEPTH), .AW(4)) unitFifo (
    .clk(clk),
    .rst(rst),
    .inValid(unitValid),
    .inReady(unitReady),
    .inData(unitData),
    .outValid(fifoValid),
    .outReady(fifoReady),
    .outData(fifoData)
  );

  // ***************************************************************
  // length table and size budget
  // ***************************************************************
  reg [15:0] lenTab [0:7];
  reg [3:0] lenCount;
  reg [15:0] sumAligned;
  reg [2:0] txState;
  wire [15:0] candHdr = `MPA_HDR_FIXED + {11'h000, lenCount, 1'b0} + 16'h0002;
  // one spare bit so a huge length cannot wrap back under the limit
  wire [16:0] candTotal = {1'b0, align4(candHdr)} + {1'b0, sumAligned} + {1'b0, lenData};
  wire lenTake = lenValid && lenReady;
  // each accepted length is budgeted as if it were the last, others padded
  wire lenFits = (lenData != 16'h0000) && (candTotal <= {1'b0, `MPA_MAX_PAYLOAD});

  assign lenReady = (txState == TX_IDLE) && (lenCount < `MPA_MAX_UNITS);
  assign txBusy = (txState != TX_IDLE);

  // ***************************************************************
  // transmit sequencing
  // ***************************************************************
  reg [15:0] txOff;
  reg [15:0] rem;
  reg [3:0] unitIdx;
  reg ieMode;
  wire load = !txValid || txReady;
  wire [15:0] nextOff = txOff + 16'h0001;
  wire [15:0] hdrEnd = `MPA_HDR_FIXED + {11'h000, lenCount, 1'b0};
  wire [3:0] hdrSel = txOff[4:1] - 4'h1;
  wire lastUnit = (unitIdx + 4'h1 == lenCount);
  wire emitUnit = (txState == TX_UNIT) && load && fifoValid;
  assign fifoReady = (txState == TX_UNIT) && load;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      txState <= TX_IDLE;
      txValid <= 1'b0;
      txData <= 8'h00;
      txLast <= 1'b0;
      txOff <= 16'h0000;
      rem <= 16'h0000;
      unitIdx <= 4'h0;
      ieMode <= 1'b0;
      lenCount <= 4'h0;
      sumAligned <= 16'h0000;
      lenRejected <= 1'b0;
      ieTxRefused <= 1'b0;
    end else begin
      lenRejected <= lenTake && !lenFits;
      ieTxRefused <= 1'b0;
      if (lenTake && lenFits) begin
        lenTab[lenCount[2:0]] <= lenData;
        lenCount <= lenCount + 4'h1;
        sumAligned <= sumAligned + align4(lenData);
      end
      if (txReady) begin
        txValid <= 1'b0;
      end
      case (txState)
        TX_IDLE: begin
          txOff <= 16'h0000;
          unitIdx <= 4'h0;
          if (aggStart && lenCount != 4'h0) begin
            ieMode <= 1'b0;
            txState <= TX_HDR;
          end else if (ieTxStart && !knownType(ieTxType)) begin
            ieTxRefused <= 1'b1;
          end else if (ieTxStart && load) begin
            ieMode <= 1'b1;
            txValid <= 1'b1;
            txData <= ieTxType;
            txLast <= 1'b0;
            txState <= TX_ILEN;
          end
        end
        TX_HDR: if (load) begin
          txValid <= 1'b1;
          txLast <= 1'b0;
          txOff <= nextOff;
          if (txOff == 16'h0000) begin
            txData <= {4'h0, lenCount};
          end else if (txOff == 16'h0001) begin
            txData <= 8'h00;
          end else if (!txOff[0]) begin
            txData <= lenTab[hdrSel[2:0]][7:0];
          end else begin
            txData <= lenTab[hdrSel[2:0]][15:8];
          end
          if (nextOff == hdrEnd) begin
            rem <= lenTab[0];
            txState <= (nextOff[1:0] != 2'b00) ? TX_PAD : TX_UNIT;
          end
        end
        TX_PAD: if (load) begin
          txValid <= 1'b1;
          txData <= 8'h00;
          txOff <= nextOff;
          if (nextOff[1:0] == 2'b00) begin
            txState <= TX_UNIT;
          end
        end
        TX_UNIT: if (emitUnit) begin
          txValid <= 1'b1;
          txData <= fifoData;
          txOff <= nextOff;
          rem <= rem - 16'h0001;
          txLast <= (rem == 16'h0001) && (ieMode || lastUnit);
          if (rem == 16'h0001) begin
            if (ieMode || lastUnit) begin
              // an element body must not discard lengths stored for a frame
              if (!ieMode) begin
                lenCount <= 4'h0;
                sumAligned <= 16'h0000;
              end
              txState <= TX_IDLE;
            end else begin
              unitIdx <= unitIdx + 4'h1;
              rem <= lenTab[unitIdx[2:0] + 3'h1];
              txState <= (nextOff[1:0] != 2'b00) ? TX_PAD : TX_UNIT;
            end
          end
        end
        TX_ILEN: if (load) begin
          txValid <= 1'b1;
          if (ieTxType == `MPA_APP_SPECIFIC) begin
            txData <= ieTxLen + `MPA_APP_ORG_OCTETS;
            txState <= TX_IORG0;
          end else begin
            txData <= ieTxLen;
            rem <= {8'h00, ieTxLen};
            txLast <= (ieTxLen == 8'h00);
            txState <= (ieTxLen == 8'h00) ? TX_IDLE : TX_UNIT;
          end
        end
        TX_IORG0: if (load) begin
          txValid <= 1'b1;
          txData <= ieTxOrg[7:0];
          txState <= TX_IORG1;
        end
        TX_IORG1: if (load) begin
          txValid <= 1'b1;
          txData <= ieTxOrg[15:8];
          rem <= {8'h00, ieTxLen};
          txLast <= (ieTxLen == 8'h00);
          txState <= (ieTxLen == 8'h00) ? TX_IDLE : TX_UNIT;
        end
        default: txState <= TX_IDLE;
      endcase
    end
  end

  // ***************************************************************
  // receive parsing
  // ***************************************************************
  localparam RX_IDLE = 3'h0;
  localparam RX_RSV = 3'h1;
  localparam RX_LEN = 3'h2;
  localparam RX_PAD = 3'h3;
  localparam RX_BODY = 3'h4;
  localparam RX_ILEN = 3'h5;
  localparam RX_IORG = 3'h6;
  localparam RX_SKIP = 3'h7;

  reg [2:0] rxState;
  reg [15:0] rxOff;
  reg [15:0] rxRem;
  reg [15:0] rxLenTab [0:7];
  reg [3:0] rxCount;
  reg [3:0] rxIdx;
  reg rxIe;
  reg rxOrgHi;
  wire [15:0] rxNextOff = rxOff + 16'h0001;
  wire [3:0] rxSel = rxOff[4:1] - 4'h1;
  wire [15:0] rxHdrEnd = `MPA_HDR_FIXED + {11'h000, rxCount, 1'b0};

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rxState <= RX_IDLE;
      rxOff <= 16'h0000;
      rxRem <= 16'h0000;
      rxCount <= 4'h0;
      rxIdx <= 4'h0;
      rxIe <= 1'b0;
      rxOrgHi <= 1'b0;
      rxOutValid <= 1'b0;
      rxOutData <= 8'h00;
      rxOutLast <= 1'b0;
      rxOutIdx <= 3'h0;
      ieStart <= 1'b0;
      ieType <= 8'h00;
      ieLength <= 8'h00;
      orgSpecValid <= 1'b0;
      orgSpec <= 16'h0000;
      rxError <= 1'b0;
    end else begin
      rxOutValid <= 1'b0;
      rxOutLast <= 1'b0;
      ieStart <= 1'b0;
      orgSpecValid <= 1'b0;
      rxError <= 1'b0;
      if (rxValid) begin
        rxOff <= rxLast ? 16'h0000 : rxNextOff;
        case (rxState)
          RX_IDLE: begin
            rxIdx <= 4'h0;
            rxIe <= rxIeMode;
            if (rxIeMode) begin
              ieType <= rxData;
              rxState <= RX_ILEN;
            end else begin
              rxCount <= (rxData[7:0] > 8'h08) ? `MPA_MAX_UNITS : rxData[3:0];
              rxError <= (rxData[7:0] > 8'h08) || (rxData == 8'h00);
              rxState <= RX_RSV;
            end
          end
          RX_RSV: rxState <= RX_LEN;
          RX_LEN: begin
            if (!rxOff[0]) begin
              rxLenTab[rxSel[2:0]][7:0] <= rxData;
            end else begin
              rxLenTab[rxSel[2:0]][15:8] <= rxData;
            end
            if (rxNextOff == rxHdrEnd) begin
              rxState <= RX_PAD;
            end
          end
          RX_PAD: if (rxOff[1:0] == 2'b00) begin
            // alignment alone decides pad length, never the length field
            rxRem <= rxLenTab[rxIdx[2:0]] - 16'h0001;
            rxOutValid <= 1'b1;
            rxOutData <= rxData;
            rxOutIdx <= rxIdx[2:0];
            rxOutLast <= (rxLenTab[rxIdx[2:0]] == 16'h0001);
            rxState <= (rxLenTab[rxIdx[2:0]] == 16'h0001) ? RX_PAD : RX_BODY;
            if (rxLenTab[rxIdx[2:0]] == 16'h0001) begin
              rxIdx <= rxIdx + 4'h1;
            end
          end
          RX_BODY: begin
            rxOutValid <= 1'b1;
            rxOutData <= rxData;
            rxOutLast <= (rxRem == 16'h0001);
            rxRem <= rxRem - 16'h0001;
            if (rxRem == 16'h0001) begin
              rxIdx <= rxIdx + 4'h1;
              rxState <= rxIe ? RX_IDLE : RX_PAD;
            end
          end
          RX_ILEN: begin
            ieLength <= rxData;
            rxRem <= {8'h00, rxData};
            ieStart <= knownType(ieType);
            if (!knownType(ieType)) begin
              rxState <= (rxData == 8'h00) ? RX_IDLE : RX_SKIP;
            end else if (ieType == `MPA_APP_SPECIFIC) begin
              rxOrgHi <= 1'b0;
              rxError <= (rxData < `MPA_APP_ORG_OCTETS);
              rxState <= (rxData < `MPA_APP_ORG_OCTETS) ? RX_SKIP : RX_IORG;
            end else begin
              rxState <= (rxData == 8'h00) ? RX_IDLE : RX_BODY;
            end
          end
          RX_IORG: begin
            rxOrgHi <= 1'b1;
            rxRem <= rxRem - 16'h0001;
            if (!rxOrgHi) begin
              orgSpec[7:0] <= rxData;
            end else begin
              orgSpec[15:8] <= rxData;
              orgSpecValid <= 1'b1;
              rxState <= (rxRem == 16'h0001) ? RX_IDLE : RX_BODY;
            end
          end
          RX_SKIP: begin
            rxRem <= rxRem - 16'h0001;
            if (rxRem <= 16'h0001) begin
              rxState <= RX_IDLE;
            end
          end
          default: rxState <= RX_IDLE;
        endcase
        if (rxLast) begin
          // a frame may end only after its last whole unit or a whole element
          rxState <= RX_IDLE;
          if (!((rxState == RX_BODY && rxRem == 16'h0001 && (rxIe || rxIdx + 4'h1 == rxCount)) ||
                (rxState == RX_PAD && rxOff[1:0] == 2'b00 && rxLenTab[rxIdx[2:0]] == 16'h0001 &&
                 rxIdx + 4'h1 == rxCount) ||
                (rxIe && rxState == RX_IORG && rxOrgHi && rxRem == 16'h0001) ||
                (rxIe && rxState == RX_SKIP && rxRem <= 16'h0001) ||
                (rxIe && rxState == RX_ILEN && rxData == 8'h00))) begin
            rxError <= 1'b1;
          end
        end
      end
    end
  end
endmodule // mpa_framer

//--- mpa_framer_properties.sv
// concurrent checks on the framer ports
`timescale 1ns/100ps
module mpa_framer_properties (
  input wire clk,
  input wire rst,
  input wire lenValid,
  input wire lenReady,
  input wire [15:0] lenData,
  input wire lenRejected,
  input wire aggStart,
  input wire ieTxStart,
  input wire [7:0] ieTxType,
  input wire [7:0] ieTxLen,
  input wire ieTxRefused,
  input wire txBusy,
  input wire txValid,
  input wire txReady,
  input wire [7:0] txData,
  input wire txLast,
  input wire rxValid,
  input wire rxOutValid,
  input wire ieStart,
  input wire [7:0] ieType
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  function automatic logic rsv(input logic [7:0] t);
    return (t >= 8'h03 && t <= 8'h07) || (t >= 8'h19 && t <= 8'hf9) || (t >= 8'hfc && t <= 8'hfe);
  endfunction
  // *****
  // element transmit steps
  // *****
  sequence s_ieGo;
    ieTxStart && !txBusy && !aggStart;
  endsequence
  sequence s_appGo;
    s_ieGo ##0 ieTxType == 8'hff;
  endsequence
  sequence s_typeOut;
    txValid && txReady && txData == 8'hff;
  endsequence
  a_zero_len_refused: assert property (lenValid && lenReady && lenData == 16'h0000 |=> lenRejected)
    else $error("zero length not refused");
  a_oversize_refused: assert property (lenValid && lenReady && lenData > 16'h07fc |=> lenRejected)
    else $error("oversize length not refused");
  a_busy_no_len: assert property (txBusy |-> !lenReady)
    else $error("length taken while busy");
  a_tx_octet_hold: assert property (txValid && !txReady |=> txValid && $stable(txData) && $stable(txLast))
    else $error("octet changed before taken");
  a_type_first: assert property (s_ieGo ##0 !rsv(ieTxType) |=> txValid && txData == $past(ieTxType))
    else $error("type octet not first");
  a_reserved_refused: assert property (s_ieGo ##0 rsv(ieTxType) |=> ieTxRefused && !txValid ##1 !txValid)
    else $error("reserved type sent");
  a_refuse_cause: assert property (ieTxRefused |-> rsv($past(ieTxType)))
    else $error("assigned type refused");
  a_app_len_field: assert property (s_appGo ##1 s_typeOut |-> ##[1:4] (txValid && txData == ieTxLen + 8'h02))
    else $error("app element length wrong");
  a_known_ie_only: assert property (ieStart |-> !rsv(ieType))
    else $error("reserved element reported");
  a_rx_latency: assert property (rxOutValid |-> $past(rxValid))
    else $error("receive output without octet");
endmodule // mpa_framer_properties
bind mpa_framer mpa_framer_properties u_props (.clk(clk), .rst(rst), .lenValid(lenValid),
  .lenReady(lenReady), .lenData(lenData), .lenRejected(lenRejected), .aggStart(aggStart),
  .ieTxStart(ieTxStart), .ieTxType(ieTxType), .ieTxLen(ieTxLen), .ieTxRefused(ieTxRefused),
  .txBusy(txBusy), .txValid(txValid), .txReady(txReady), .txData(txData), .txLast(txLast),
  .rxValid(rxValid), .rxOutValid(rxOutValid), .ieStart(ieStart), .ieType(ieType));

//--- mpa_peer.sv
// far-side frame sink with optional stalls
`timescale 1ns/100ps
module mpa_peer (
  input wire clk,
  input wire rst,
  input wire stall,
  input wire txValid,
  input wire [7:0] txData,
  input wire txLast,
  output reg txReady
);
  logic [8:0] got[$];
  logic ph;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      txReady <= 1'b0;
      ph <= 1'b0;
    end else begin
      ph <= ~ph;
      // alternate stalls prove octets stand until taken
      txReady <= !stall || ph;
      if (txValid && txReady) got.push_back({txLast, txData});
    end
  end
endmodule // mpa_peer

//--- mpa_regs.vh
// constants for the aggregated payload and element framer
// ***************************************************************
// Notes on behaviour
// ***************************************************************
`ifndef MPA_REGS_VH
`define MPA_REGS_VH
`define MPA_ALIGN_MASK 16'h0003
`define MPA_HDR_FIXED 16'h0002
`define MPA_MAX_PAYLOAD 16'h0800
`define MPA_MAX_UNITS 4'h8
`define MPA_FIFO_DEPTH 16
`define MPA_APP_SPECIFIC 8'hff
`define MPA_APP_ORG_OCTETS 8'h02
`endif

//--- test_mpa_framer.sv
// self-checking bench for the framer
`timescale 1ns/100ps
module test_mpa_framer;
  logic clk = 0, rst = 1, lenValid = 0, aggStart = 0, ieTxStart = 0, unitValid = 0;
  logic rxIeMode = 0, rxValid = 0, rxLast = 0, stall = 0;
  logic [15:0] lenData = 16'h0000, ieTxOrg = 16'h0000, orgSeen = 16'h0000;
  logic [7:0] ieTxType = 8'h00, ieTxLen = 8'h00, unitData = 8'h00, rxData = 8'h00;
  wire lenReady, lenRejected, ieTxRefused, unitReady, txBusy, txValid, txReady, txLast;
  wire rxOutValid, rxOutLast, ieStart, orgSpecValid, rxError;
  wire [7:0] txData, rxOutData, ieType, ieLength;
  wire [2:0] rxOutIdx;
  wire [15:0] orgSpec;
  int fail_count = 0, tests_run = 0, errs = 0;
  logic [7:0] exp[$];
  logic [11:0] rq[$];
  logic [15:0] ieq[$];
  always #2.5 clk = ~clk;
  mpa_framer DUT (.clk(clk), .rst(rst), .lenValid(lenValid), .lenReady(lenReady), .lenData(lenData),
    .lenRejected(lenRejected), .aggStart(aggStart), .ieTxStart(ieTxStart), .ieTxType(ieTxType),
    .ieTxLen(ieTxLen), .ieTxOrg(ieTxOrg), .ieTxRefused(ieTxRefused), .unitValid(unitValid),
    .unitReady(unitReady), .unitData(unitData), .txBusy(txBusy), .txValid(txValid), .txReady(txReady),
    .txData(txData), .txLast(txLast), .rxIeMode(rxIeMode), .rxValid(rxValid), .rxData(rxData),
    .rxLast(rxLast), .rxOutValid(rxOutValid), .rxOutData(rxOutData), .rxOutLast(rxOutLast),
    .rxOutIdx(rxOutIdx), .ieStart(ieStart), .ieType(ieType), .ieLength(ieLength),
    .orgSpecValid(orgSpecValid), .orgSpec(orgSpec), .rxError(rxError));
  mpa_peer u_peer (.clk(clk), .rst(rst), .stall(stall), .txValid(txValid), .txData(txData),
    .txLast(txLast), .txReady(txReady));
  always @(posedge clk) begin
    if (rxOutValid) rq.push_back({rxOutLast, rxOutIdx, rxOutData});
    if (ieStart) ieq.push_back({ieType, ieLength});
    if (orgSpecValid) orgSeen = orgSpec;
    if (rxError) errs++;
  end
  task chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask
  task finish_test;
    $display("mismatches %0d of %0d checks", fail_count, tests_run);
    if (fail_count == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task push(input int n, output int k);
    k = 0;
    // valid only rises while ready, so nothing is ever withdrawn
    @(negedge clk);
    while (k < n && unitReady) begin
      unitValid = 1;
      unitData = 8'h40 + k[7:0];
      k++;
      @(negedge clk);
    end
    unitValid = 0;
  endtask
  // selector, not a signal argument: task arguments copy out only on return
  task pulse(input int sel);
    @(negedge clk);
    if (sel == 0) aggStart = 1;
    else ieTxStart = 1;
    @(negedge clk);
    aggStart = 0;
    ieTxStart = 0;
  endtask
  task cmp_tx;
    repeat (600) if (u_peer.got.size() < exp.size() || txBusy) @(negedge clk);
    chk(u_peer.got.size(), exp.size());
    foreach (exp[i]) chk(u_peer.got[i], {i == exp.size() - 1, exp[i]});
    u_peer.got.delete();
  endtask
  task rx_feed;
    rq.delete();
    foreach (exp[i]) begin
      @(negedge clk);
      rxValid = 1;
      rxData = exp[i];
      rxLast = (i == exp.size() - 1);
    end
    @(negedge clk);
    rxValid = 0;
    rxLast = 0;
    rxData = ~rxData;
    repeat (3) @(negedge clk);
  endtask
  task t_len;
    @(negedge clk);
    lenValid = 1;
    lenData = 16'h0000;
    @(negedge clk);
    chk(lenRejected, 1);
    lenData = 16'h0800;
    @(negedge clk);
    chk(lenRejected, 1);
    lenData = 16'hfffd;
    @(negedge clk);
    lenValid = 0;
    chk(lenRejected, 1);
    pulse(0);
    chk(txBusy, 0);
  endtask
  task t_agg;
    int k;
    push(6, k);
    @(negedge clk);
    lenValid = 1;
    lenData = 16'h0001;
    @(negedge clk);
    chk(lenRejected, 0);
    lenData = 16'h0005;
    @(negedge clk);
    lenValid = 0;
    chk(lenRejected, 0);
    stall = 1;
    pulse(0);
    // two units: header 6, pad 2, unit at 8, pad 3, unit at 12
    exp = '{8'h02, 8'h00, 8'h01, 8'h00, 8'h05, 8'h00, 8'h00, 8'h00, 8'h40, 8'h00, 8'h00, 8'h00,
            8'h41, 8'h42, 8'h43, 8'h44, 8'h45};
    cmp_tx();
    stall = 0;
    rx_feed();
    chk(rq.size(), 6);
    chk(rq[0], {1'b1, 3'h0, 8'h40});
    chk(rq[1], {1'b0, 3'h1, 8'h41});
    chk(rq[5], {1'b1, 3'h1, 8'h45});
  endtask
  task t_ie;
    int k;
    logic [7:0] rs[6];
    rs = '{8'h03, 8'h07, 8'h19, 8'hf9, 8'hfc, 8'hfe};
    push(40, k);
    chk(k >= 16, 1);
    stall = 1;
    ieTxType = 8'hff;
    ieTxLen = k[7:0];
    ieTxOrg = 16'hbeef;
    pulse(1);
    exp = '{8'hff, k[7:0] + 8'h02, 8'hef, 8'hbe};
    for (int i = 0; i < k; i++) exp.push_back(8'h40 + i[7:0]);
    cmp_tx();
    stall = 0;
    foreach (rs[i]) begin
      ieTxType = rs[i];
      pulse(1);
      chk(ieTxRefused, 1);
    end
    ieTxType = 8'h00;
    ieTxLen = 8'h00;
    pulse(1);
    exp = '{8'h00, 8'h00};
    cmp_tx();
    ieTxType = 8'hff;
    ieTxOrg = 16'h5aa5;
    pulse(1);
    exp = '{8'hff, 8'h02, 8'ha5, 8'h5a};
    cmp_tx();
  endtask
  task t_rx_ie;
    rxIeMode = 1;
    ieq.delete();
    exp = '{8'h05, 8'h02, 8'haa, 8'hbb, 8'hff, 8'h03, 8'h34, 8'h12, 8'h77, 8'h0a, 8'h01, 8'h55};
    rx_feed();
    chk(ieq.size(), 2);
    chk(ieq[0], 16'hff03);
    chk(ieq[1], 16'h0a01);
    chk(orgSeen, 16'h1234);
    chk({rq[$][11], rq[$][7:0]}, 9'h155);
    chk(errs, 0);
    exp = '{8'hff, 8'h02, 8'hcd, 8'hab};
    rx_feed();
    chk(orgSeen, 16'habcd);
    chk(errs, 0);
    exp = '{8'hff, 8'h05, 8'h01};
    rx_feed();
    chk(errs > 0, 1);
  endtask
  initial begin
    #100000;
    fail_count++;
    finish_test();
  end
  initial begin
    repeat (3) @(negedge clk);
    rst = 0;
    t_len();
    t_agg();
    t_ie();
    t_rx_ie();
    finish_test();
  end
endmodule // test_mpa_framer
